// >>> hw/ctx_dir_check.sv
/*
 * Context and directory entry check for inbound DMA requests.
 * Software loads a context entry, a directory entry and a request over
 * classic Wishbone, then sets the go bit; one cycle later the verdict,
 * the fault-report decision and the next table address appear.
 * Assumes the walker outside fetches the entries from memory.
 */
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
// Summary of operation
// - page-request allow reads zero without support
// - bit 4 blocks or allows page requests
// - process id enable zero without support
// - bit 3 blocks or translates tagged untranslated and translation requests
// - untagged handling ignores process id enable
// - atc allow reads zero without support
// - bit 2 clear blocks translation and translated
// - bit 2 set translates, translated pass through
// - context bit 1 suppresses fault reports
// - suppress bits read even when absent
// - context bit 0 clear means not present
// - directory bits 63:12 give 4KB table base
// - base bits above host width read zero
// - table base is host physical, untranslated
// - directory bit 1 suppresses unless context does
// - directory bit 0 clear means not present
// - directory holds two to size plus seven
// - untagged use default pid, execute zero
module ctx_dir_check #(
    parameter int HostAddrWidth = ctx_dir_pkg::HostAddrWidthDef
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic completionFail,
    output logic faultRaise
);
    localparam int PidW_l = ctx_dir_pkg::PidW;

    logic [31:0] ctxLoReg;
    logic [31:0] ctxHiReg;
    logic [31:0] ctxDefReg;
    logic [31:0] dirLoReg;
    logic [31:0] dirHiReg;
    logic [31:0] capReg;
    logic [31:0] reqReg;
    logic [2:0] verdictReg;
    logic suppressReg;
    logic [PidW_l-1:0] effPidReg;
    logic effExecReg;
    logic [63:0] nextAddrReg;
    logic [15:0] faultCntReg;
    logic failReg;
    logic faultReg;
    logic goPulse;
    logic wbHit;
    logic wbWrite;

    logic ctxPresent;
    logic ctxSuppress;
    logic pageReqAllow;
    logic processIdEnable;
    logic atcRequestAllow;
    logic [2:0] pidDirSize;

    ctx_entry_decode u_ctx_decode (
        .ctxLo(ctxLoReg[11:0]),
        .pageReqSupported(capReg[ctx_dir_pkg::CapPageReqBit]),
        .processIdSupported(capReg[ctx_dir_pkg::CapPidBit]),
        .atcSupported(capReg[ctx_dir_pkg::CapAtcBit]),
        .present(ctxPresent),
        .faultReportSuppress(ctxSuppress),
        .pageReqAllow(pageReqAllow),
        .processIdEnable(processIdEnable),
        .atcRequestAllow(atcRequestAllow),
        .pidDirSize(pidDirSize)
    );

    // bus slave: ack one cycle after the strobe, dropped the cycle after
    assign wbHit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // writes land on the ack edge, the one edge the master sees the end
    assign wbWrite = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
    assign goPulse = wbWrite & (wb_adr_i == ctx_dir_pkg::RegReq)
        & wb_sel_i[3] & wb_dat_i[ctx_dir_pkg::ReqGoBit];

    function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                               input logic [31:0] dat,
                                               input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[8*i +: 8] = dat[8*i +: 8];
            end
        end
        return res;
    endfunction : mergeBytes

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wbHit;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ctxLoReg <= 32'h0000_0000;
            ctxHiReg <= 32'h0000_0000;
            ctxDefReg <= 32'h0000_0000;
            dirLoReg <= 32'h0000_0000;
            dirHiReg <= 32'h0000_0000;
            capReg <= ctx_dir_pkg::CapResetVal;
            reqReg <= 32'h0000_0000;
        end else if (wbWrite) begin
            unique case (wb_adr_i)
                ctx_dir_pkg::RegCtxLo: ctxLoReg <= mergeBytes(ctxLoReg, wb_dat_i, wb_sel_i);
                ctx_dir_pkg::RegCtxHi: ctxHiReg <= mergeBytes(ctxHiReg, wb_dat_i, wb_sel_i);
                ctx_dir_pkg::RegCtxDef: ctxDefReg <= mergeBytes(ctxDefReg, wb_dat_i, wb_sel_i);
                ctx_dir_pkg::RegDirLo: dirLoReg <= mergeBytes(dirLoReg, wb_dat_i, wb_sel_i);
                ctx_dir_pkg::RegDirHi: dirHiReg <= mergeBytes(dirHiReg, wb_dat_i, wb_sel_i);
                ctx_dir_pkg::RegCap: capReg <= mergeBytes(capReg, wb_dat_i, wb_sel_i);
                ctx_dir_pkg::RegReq: reqReg <= mergeBytes(reqReg, wb_dat_i, wb_sel_i);
                default: ;
            endcase
        end
    end

    // request decode
    logic [1:0] reqKind;
    logic reqTagged;
    logic [PidW_l-1:0] reqPid;
    logic [PidW_l-1:0] effPid;
    logic effExec;
    logic [13:0] dirIdx;
    logic pidInRange;
    logic [63:0] dirEntryAddr;
    logic [63:0] tableBase;
    logic [63:0] tableEntryAddr;
    logic dirPresent;
    logic dirSuppress;
    logic suppressAll;
    logic [2:0] verdictNext;
    logic [4:0] sizeLog;
    logic [63:0] haMask;

    assign reqKind = reqReg[ctx_dir_pkg::ReqKindLo +: 2];
    assign reqTagged = reqReg[ctx_dir_pkg::ReqTaggedBit];
    assign reqPid = reqReg[ctx_dir_pkg::ReqPidLo +: PidW_l];

    always_comb begin
        // untagged requests borrow the default id and never execute
        if (reqTagged) begin
            effPid = reqPid;
            effExec = reqReg[ctx_dir_pkg::ReqExecBit];
        end else begin
            effPid = ctxDefReg[ctx_dir_pkg::CtxDefPidLo +: PidW_l];
            effExec = 1'b0;
        end
    end

    // directory has 2^(size+7) entries, indexed by the upper id bits
    assign sizeLog = 5'(pidDirSize) + 5'(ctx_dir_pkg::DirSizeBias);
    assign dirIdx = effPid[PidW_l-1:ctx_dir_pkg::PidTableIdxW];
    assign pidInRange = (32'(dirIdx) >> sizeLog) == 32'h0000_0000;

    // bits at and above the host width are forced to zero
    assign haMask = (64'h1 << HostAddrWidth) - 64'h1;
    // both bases are host physical: no stage of translation is applied
    assign dirEntryAddr = ({ctxHiReg, ctxLoReg[31:ctx_dir_pkg::CtxDirBaseLo], 12'h000} & haMask)
        + 64'({dirIdx, 3'h0});
    assign tableBase = {dirHiReg, dirLoReg[31:ctx_dir_pkg::DirBaseLo], 12'h000} & haMask;
    assign tableEntryAddr = tableBase
        + 64'({effPid[ctx_dir_pkg::PidTableIdxW-1:0], 6'h00});

    // suppress bits count even for absent entries
    assign dirPresent = dirLoReg[ctx_dir_pkg::DirPresentBit];
    assign dirSuppress = dirLoReg[ctx_dir_pkg::DirSuppressBit];
    // directory bit only matters when context does not suppress
    assign suppressAll = ctxSuppress | dirSuppress;

    always_comb begin
        verdictNext = ctx_dir_pkg::VERD_OK;
        if (!ctxPresent) begin
            verdictNext = ctx_dir_pkg::VERD_CTX_ABSENT;
        end else begin
            unique case (reqKind)
                ctx_dir_pkg::REQ_PAGE: begin
                    if (!pageReqAllow) begin
                        verdictNext = ctx_dir_pkg::VERD_BLOCKED;
                    end
                end
                ctx_dir_pkg::REQ_TRANSLATED: begin
                    if (!atcRequestAllow) begin
                        verdictNext = ctx_dir_pkg::VERD_BLOCKED;
                    end else begin
                        verdictNext = ctx_dir_pkg::VERD_PASS;
                    end
                end
                default: begin
                    // pid enable only gates tagged traffic
                    if (reqTagged && !processIdEnable) begin
                        verdictNext = ctx_dir_pkg::VERD_BLOCKED;
                    end else if (reqKind == ctx_dir_pkg::REQ_TRANSLATION && !atcRequestAllow) begin
                        verdictNext = ctx_dir_pkg::VERD_BLOCKED;
                    end else if (!pidInRange) begin
                        verdictNext = ctx_dir_pkg::VERD_PID_RANGE;
                    end else if (!dirPresent) begin
                        verdictNext = ctx_dir_pkg::VERD_DIR_ABSENT;
                    end else begin
                        verdictNext = ctx_dir_pkg::VERD_OK;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            verdictReg <= 3'h0;
            suppressReg <= 1'b0;
            effPidReg <= '0;
            effExecReg <= 1'b0;
            nextAddrReg <= 64'h0;
        end else if (goPulse) begin
            verdictReg <= verdictNext;
            // the directory is only reached when context is present
            suppressReg <= ctxPresent ? suppressAll : ctxSuppress;
            effPidReg <= effPid;
            effExecReg <= effExec;
            nextAddrReg <= dirPresent ? tableEntryAddr : dirEntryAddr;
        end
    end

    // failure and fault strobes, one cycle after go
    logic isFail;
    assign isFail = (verdictNext != ctx_dir_pkg::VERD_OK)
        && (verdictNext != ctx_dir_pkg::VERD_PASS);

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            failReg <= 1'b0;
            faultReg <= 1'b0;
            faultCntReg <= 16'h0000;
        end else begin
            failReg <= goPulse & isFail;
            faultReg <= goPulse & isFail
                & ~(ctxPresent ? suppressAll : ctxSuppress);
            if (goPulse && isFail && !(ctxPresent ? suppressAll : ctxSuppress)) begin
                faultCntReg <= faultCntReg + 16'h0001;
            end
        end
    end

    assign completionFail = failReg;
    assign faultRaise = faultReg;

    // read mux, registered with the ack
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wbHit && !wb_we_i) begin
            unique case (wb_adr_i)
                ctx_dir_pkg::RegCtxLo: wb_dat_o <= ctxLoReg;
                ctx_dir_pkg::RegCtxHi: wb_dat_o <= ctxHiReg;
                ctx_dir_pkg::RegCtxDef: wb_dat_o <= ctxDefReg;
                ctx_dir_pkg::RegDirLo: wb_dat_o <= dirLoReg;
                ctx_dir_pkg::RegDirHi: wb_dat_o <= dirHiReg;
                ctx_dir_pkg::RegCap: wb_dat_o <= capReg;
                ctx_dir_pkg::RegReq: wb_dat_o <= {1'b0, reqReg[30:0]};
                ctx_dir_pkg::RegResult: wb_dat_o <= {effExecReg, 2'h0, effPidReg,
                    3'h0, suppressReg, pageReqAllow, processIdEnable, verdictReg};
                ctx_dir_pkg::RegAddrLo: wb_dat_o <= nextAddrReg[31:0];
                ctx_dir_pkg::RegAddrHi: wb_dat_o <= nextAddrReg[63:32];
                ctx_dir_pkg::RegFaultCnt: wb_dat_o <= {16'h0000, faultCntReg};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    a_bus_ack_once: assert property (@(posedge clk_sys) disable iff (!rst_b)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    a_fault_needs_fail: assert property (@(posedge clk_sys) disable iff (!rst_b)
        faultRaise |-> completionFail)
        else $error("fault without failed completion");
    a_ctx_suppress_quiet: assert property (@(posedge clk_sys) disable iff (!rst_b)
        goPulse && ctxSuppress |=> !faultRaise)
        else $error("fault reported under context suppress");
    a_absent_ctx_fails: assert property (@(posedge clk_sys) disable iff (!rst_b)
        goPulse && !ctxPresent |=> completionFail)
        else $error("absent context not failed");
    a_page_block: assert property (@(posedge clk_sys) disable iff (!rst_b)
        goPulse && ctxPresent && reqKind == ctx_dir_pkg::REQ_PAGE && !pageReqAllow
        |=> completionFail)
        else $error("page request not blocked");
    a_pid_unsupported: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !capReg[ctx_dir_pkg::CapPidBit] |-> !processIdEnable)
        else $error("pid enable not masked");
    a_translated_pass: assert property (@(posedge clk_sys) disable iff (!rst_b)
        goPulse && ctxPresent && reqKind == ctx_dir_pkg::REQ_TRANSLATED && atcRequestAllow
        |=> verdictReg == ctx_dir_pkg::VERD_PASS && !completionFail)
        else $error("translated request not passed");
    a_untagged_noexec: assert property (@(posedge clk_sys) disable iff (!rst_b)
        goPulse && !reqTagged |=> !effExecReg)
        else $error("untagged request kept execute");
    a_dir_suppress: assert property (@(posedge clk_sys) disable iff (!rst_b)
        goPulse && ctxPresent && dirSuppress |=> !faultRaise)
        else $error("fault under directory suppress");
    a_page_masked: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !capReg[ctx_dir_pkg::CapPageReqBit] |-> !pageReqAllow)
        else $error("page request allow not masked");
    a_atc_masked: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !capReg[ctx_dir_pkg::CapAtcBit] |-> !atcRequestAllow)
        else $error("atc allow not masked");
    a_tagged_block: assert property (@(posedge clk_sys) disable iff (!rst_b)
        goPulse && ctxPresent && reqTagged && !processIdEnable
        && reqKind == ctx_dir_pkg::REQ_UNTRANSLATED |=> completionFail)
        else $error("tagged request not blocked");
    a_atc_block: assert property (@(posedge clk_sys) disable iff (!rst_b)
        goPulse && ctxPresent && !atcRequestAllow
        && (reqKind == ctx_dir_pkg::REQ_TRANSLATION || reqKind == ctx_dir_pkg::REQ_TRANSLATED)
        |=> completionFail)
        else $error("translation traffic not blocked");
    a_untagged_free: assert property (@(posedge clk_sys) disable iff (!rst_b)
        goPulse && ctxPresent && !reqTagged && reqKind == ctx_dir_pkg::REQ_UNTRANSLATED
        && pidInRange && dirPresent |=> verdictReg == ctx_dir_pkg::VERD_OK)
        else $error("untagged request not translated");
    a_dir_absent_fails: assert property (@(posedge clk_sys) disable iff (!rst_b)
        goPulse && ctxPresent && !dirPresent && reqKind == ctx_dir_pkg::REQ_UNTRANSLATED
        && !reqTagged |=> completionFail)
        else $error("absent directory entry not failed");
    a_untagged_pid: assert property (@(posedge clk_sys) disable iff (!rst_b)
        goPulse && !reqTagged
        |=> effPidReg == ctxDefReg[ctx_dir_pkg::CtxDefPidLo +: PidW_l])
        else $error("untagged request not given default id");
    a_addr_host_width: assert property (@(posedge clk_sys) disable iff (!rst_b)
        goPulse && dirPresent
        |=> (nextAddrReg >> HostAddrWidth) == 64'h0)
        else $error("table address above host width");
endmodule : ctx_dir_check

// >>> hw/ctx_dir_pkg.sv
/*
 * Constants for the context / directory entry decode block: entry field
 * positions, request kinds, verdict codes and the bus register map.
 * Assumes a single 250 MHz clock domain and a classic Wishbone slave.
 */
package ctx_dir_pkg;
    // context entry low word
    localparam int CtxPresentBit = 0;
    localparam int CtxSuppressBit = 1;
    localparam int CtxAtcAllowBit = 2;
    localparam int CtxPidEnableBit = 3;
    localparam int CtxPageReqBit = 4;
    localparam int CtxRsvdLo = 5;
    localparam int CtxRsvdHi = 8;
    localparam int CtxDirSizeLo = 9;
    localparam int CtxDirSizeW = 3;
    localparam int CtxDirBaseLo = 12;
    // context entry second word: default process id, bits 83:64
    localparam int CtxDefPidLo = 0;
    localparam int PidW = 20;
    localparam int DirSizeBias = 7;
    // directory entry
    localparam int DirPresentBit = 0;
    localparam int DirSuppressBit = 1;
    localparam int DirBaseLo = 12;
    localparam int PidTableIdxW = 6;
    localparam int PidTableEntryShift = 6;
    localparam int HostAddrWidthDef = 48;

    typedef enum logic [1:0] {
        REQ_UNTRANSLATED,
        REQ_TRANSLATION,
        REQ_TRANSLATED,
        REQ_PAGE
    } req_kind_e;

    typedef enum logic [2:0] {
        VERD_OK,
        VERD_PASS,
        VERD_CTX_ABSENT,
        VERD_DIR_ABSENT,
        VERD_BLOCKED,
        VERD_PID_RANGE
    } verdict_e;

    // wishbone register byte offsets
    localparam logic [7:0] RegCtxLo = 8'h00;
    localparam logic [7:0] RegCtxHi = 8'h04;
    localparam logic [7:0] RegCtxDef = 8'h08;
    localparam logic [7:0] RegDirLo = 8'h0c;
    localparam logic [7:0] RegDirHi = 8'h10;
    localparam logic [7:0] RegCap = 8'h14;
    localparam logic [7:0] RegReq = 8'h18;
    localparam logic [7:0] RegResult = 8'h1c;
    localparam logic [7:0] RegAddrLo = 8'h20;
    localparam logic [7:0] RegAddrHi = 8'h24;
    localparam logic [7:0] RegFaultCnt = 8'h28;
    localparam logic [31:0] CapResetVal = 32'h0000_0007;
    localparam int CapPageReqBit = 0;
    localparam int CapPidBit = 1;
    localparam int CapAtcBit = 2;
    localparam int ReqKindLo = 0;
    localparam int ReqTaggedBit = 2;
    localparam int ReqExecBit = 3;
    localparam int ReqPidLo = 8;
    localparam int ReqGoBit = 31;
endpackage : ctx_dir_pkg

// >>> hw/ctx_entry_decode.sv
/*
 * Combinational decode of the low control bits of a context entry,
 * masked by the implementation's capability bits.
 * Assumes the caller registers the outputs it needs.
 */
`timescale 1ns/10ps
module ctx_entry_decode (
    input wire logic [11:0] ctxLo,
    input wire logic pageReqSupported,
    input wire logic processIdSupported,
    input wire logic atcSupported,
    output logic present,
    output logic faultReportSuppress,
    output logic pageReqAllow,
    output logic processIdEnable,
    output logic atcRequestAllow,
    output logic [2:0] pidDirSize
);
    always_comb begin
        present = ctxLo[ctx_dir_pkg::CtxPresentBit];
        // suppress is read whether or not the entry is present
        faultReportSuppress = ctxLo[ctx_dir_pkg::CtxSuppressBit];
        // unsupported features read as zero whatever software wrote
        pageReqAllow = ctxLo[ctx_dir_pkg::CtxPageReqBit] & pageReqSupported;
        processIdEnable = ctxLo[ctx_dir_pkg::CtxPidEnableBit] & processIdSupported;
        atcRequestAllow = ctxLo[ctx_dir_pkg::CtxAtcAllowBit] & atcSupported;
        pidDirSize = ctxLo[ctx_dir_pkg::CtxDirSizeLo +: ctx_dir_pkg::CtxDirSizeW];
    end
endmodule : ctx_entry_decode

// >>> testbench/dma_remap_context_dir_decode_tb.sv
/*
 * Self-checking bench for ctx_dir_check: loads entries and requests over
 * classic Wishbone and compares verdicts, pulses and next-table address.
 * Assumes the default host address width of 48 bits.
 */
`timescale 1ns/10ps
module dma_remap_context_dir_decode_tb;
    localparam logic [19:0] TableBase = 20'h12345;
    localparam logic [19:0] DefPid = 20'h00005;
    localparam logic [2:0] VOk = ctx_dir_pkg::VERD_OK;
    localparam logic [2:0] VPass = ctx_dir_pkg::VERD_PASS;
    localparam logic [2:0] VCtxAbs = ctx_dir_pkg::VERD_CTX_ABSENT;
    localparam logic [2:0] VDirAbs = ctx_dir_pkg::VERD_DIR_ABSENT;
    localparam logic [2:0] VBlk = ctx_dir_pkg::VERD_BLOCKED;
    localparam logic [2:0] VRange = ctx_dir_pkg::VERD_PID_RANGE;
    localparam logic [1:0] KUn = 2'h0;
    localparam logic [1:0] KTr = 2'h1;
    localparam logic [1:0] KTd = 2'h2;
    localparam logic [1:0] KPg = 2'h3;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic completionFail;
    logic faultRaise;
    logic [4:0] ctxFlags = 5'h00;
    logic [2:0] dirSize = 3'h0;
    logic [1:0] dirFlags = 2'h0;
    logic [31:0] ctxLo;
    logic [31:0] dirLo;
    logic [31:0] rdData;
    int n_fail = 0;
    int checks_done = 0;
    int nCf = 0;
    int nFr = 0;
    int expFaults = 0;

    ctx_dir_check i_dut (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .completionFail(completionFail),
        .faultRaise(faultRaise)
    );

    entry_builder i_mem (
        .ctxFlags(ctxFlags),
        .dirSize(dirSize),
        .dirFlags(dirFlags),
        .tableBase(TableBase),
        .ctxLo(ctxLo),
        .dirLo(dirLo)
    );

    always #2 clk_sys = ~clk_sys;

    // pulses are counted rather than timed: only their number is fixed
    always @(posedge clk_sys) begin
        if (completionFail === 1'b1) nCf++;
        if (faultRaise === 1'b1) nFr++;
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude

    task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : compare

    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int i;
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= 4'hf;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            if (wb_ack_o === 1'b1) break;
        end
        rdData = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (i == 20) begin
            n_fail++;
            $display("[FAIL] bus ack expected 1 seen 0");
            conclude();
        end
    endtask : wb

    task automatic chk(input logic [4:0] cf, input logic [1:0] df, input logic [2:0] sz,
                       input logic [1:0] kind, input logic tag, input logic [19:0] pid,
                       input logic [2:0] expV, input logic expFault);
        logic [31:0] req;
        logic [19:0] ePid;
        ctxFlags = cf;
        dirFlags = df;
        dirSize = sz;
        #1;
        wb(1'b1, ctx_dir_pkg::RegCtxLo, ctxLo);
        wb(1'b1, ctx_dir_pkg::RegDirLo, dirLo);
        // exec always requested so that its clearing can be seen
        req = {4'h0, pid, 4'h0, 1'b1, tag, kind};
        wb(1'b1, ctx_dir_pkg::RegReq, req);
        nCf = 0;
        nFr = 0;
        wb(1'b1, ctx_dir_pkg::RegReq, req | 32'h8000_0000);
        repeat (3) @(posedge clk_sys);
        compare("fail pulses", {31'h0, expV >= VCtxAbs}, nCf);
        compare("fault pulses", {31'h0, expFault}, nFr);
        if (expFault) expFaults++;
        wb(1'b0, ctx_dir_pkg::RegResult, 32'h0);
        compare("verdict", {29'h0, expV}, {29'h0, rdData[2:0]});
        compare("suppress", {31'h0, cf[1] | (cf[0] & df[1])}, {31'h0, rdData[5]});
        if (kind == KUn && expV == VOk) begin
            ePid = tag ? pid : DefPid;
            compare("effective pid", {12'h0, ePid}, {12'h0, rdData[28:9]});
            compare("exec", {31'h0, tag}, {31'h0, rdData[31]});
            wb(1'b0, ctx_dir_pkg::RegAddrLo, 32'h0);
            compare("addr lo", {TableBase, 12'h0} + ePid[5:0] * 64, rdData);
            wb(1'b0, ctx_dir_pkg::RegAddrHi, 32'h0);
            compare("addr hi", 32'h0000_0abc, rdData);
        end
    endtask : chk

    initial begin
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        wb(1'b0, ctx_dir_pkg::RegCap, 32'h0);
        compare("cap reset", ctx_dir_pkg::CapResetVal, rdData);
        wb(1'b0, ctx_dir_pkg::RegResult, 32'h0);
        compare("result reset", 32'h0, rdData);
        wb(1'b0, 8'h30, 32'h0);
        compare("unmapped read", 32'h0, rdData);
        wb(1'b1, ctx_dir_pkg::RegCtxDef, {12'h0, DefPid});
        wb(1'b1, ctx_dir_pkg::RegCtxHi, 32'h0);
        // host address bits above 47 set on purpose
        wb(1'b1, ctx_dir_pkg::RegDirHi, 32'hffff_0abc);
        chk(5'h1d, 2'h1, 3'h7, KUn, 1'b0, 20'h00777, VOk, 1'b0);
        chk(5'h1d, 2'h1, 3'h7, KTr, 1'b0, 20'h0, VOk, 1'b0);
        chk(5'h1d, 2'h1, 3'h7, KTd, 1'b0, 20'h0, VPass, 1'b0);
        chk(5'h19, 2'h1, 3'h7, KTr, 1'b1, 20'h40, VBlk, 1'b1);
        chk(5'h19, 2'h1, 3'h7, KTd, 1'b0, 20'h0, VBlk, 1'b1);
        chk(5'h15, 2'h1, 3'h7, KUn, 1'b1, 20'h40, VBlk, 1'b1);
        chk(5'h15, 2'h1, 3'h7, KUn, 1'b0, 20'h0, VOk, 1'b0);
        chk(5'h1d, 2'h1, 3'h7, KUn, 1'b1, 20'h00ac3, VOk, 1'b0);
        chk(5'h1d, 2'h1, 3'h7, KPg, 1'b0, 20'h0, VOk, 1'b0);
        chk(5'h0d, 2'h1, 3'h7, KPg, 1'b0, 20'h0, VBlk, 1'b1);
        chk(5'h1b, 2'h1, 3'h7, KTr, 1'b0, 20'h0, VBlk, 1'b0);
        chk(5'h1c, 2'h1, 3'h7, KUn, 1'b0, 20'h0, VCtxAbs, 1'b1);
        chk(5'h1e, 2'h1, 3'h7, KUn, 1'b0, 20'h0, VCtxAbs, 1'b0);
        chk(5'h1d, 2'h0, 3'h7, KUn, 1'b0, 20'h0, VDirAbs, 1'b1);
        chk(5'h1d, 2'h2, 3'h7, KUn, 1'b0, 20'h0, VDirAbs, 1'b0);
        chk(5'h1f, 2'h0, 3'h7, KUn, 1'b0, 20'h0, VDirAbs, 1'b0);
        chk(5'h1d, 2'h1, 3'h0, KUn, 1'b1, 20'h02000, VRange, 1'b1);
        chk(5'h1d, 2'h1, 3'h0, KUn, 1'b1, 20'h01fff, VOk, 1'b0);
        // no feature supported: enables written high must read as zero
        wb(1'b1, ctx_dir_pkg::RegCap, 32'h0);
        chk(5'h1d, 2'h1, 3'h7, KPg, 1'b0, 20'h0, VBlk, 1'b1);
        chk(5'h1d, 2'h1, 3'h7, KUn, 1'b1, 20'h40, VBlk, 1'b1);
        chk(5'h1d, 2'h1, 3'h7, KTr, 1'b0, 20'h0, VBlk, 1'b1);
        compare("enables", 32'h0, {30'h0, rdData[4:3]});
        chk(5'h1d, 2'h1, 3'h7, KUn, 1'b0, 20'h0, VOk, 1'b0);
        wb(1'b0, ctx_dir_pkg::RegFaultCnt, 32'h0);
        compare("fault count", expFaults, rdData);
        conclude();
    end
endmodule : dma_remap_context_dir_decode_tb

// >>> testbench/entry_builder.sv
/*
 * Software side of the entry structures: builds context and directory
 * entry low words from their fields, as they would sit in memory.
 * Assumes the bench copies the words into the block's entry registers.
 */
`timescale 1ns/10ps
module entry_builder (
    input wire logic [4:0] ctxFlags,
    input wire logic [2:0] dirSize,
    input wire logic [1:0] dirFlags,
    input wire logic [19:0] tableBase,
    output logic [31:0] ctxLo,
    output logic [31:0] dirLo
);
    // reserved context bits 8:5 always left zero
    assign ctxLo = {20'h00100, dirSize, 4'h0, ctxFlags};
    // directory reserved bits 11:2 zero as well
    assign dirLo = {tableBase, 10'h000, dirFlags};
endmodule : entry_builder
